//--- rtl/ssid_pkg.sv
// Constants and types for the serial port status, interrupt and DMA block
package ssid_pkg;
   localparam logic [7:0] OFS_FIFO_STATUS = 8'h0C;
   localparam logic [7:0] OFS_PRESCALE = 8'h10;
   localparam logic [7:0] OFS_IRQ_ENABLE = 8'h14;
   localparam logic [7:0] OFS_RAW_STATUS = 8'h18;
   localparam logic [7:0] OFS_MASKED_STATUS = 8'h1C;
   localparam logic [7:0] OFS_IRQ_CLEAR = 8'h20;
   localparam logic [7:0] OFS_DMA_CONTROL = 8'h24;
   localparam logic [4:0] FIFO_FULL_LEVEL = 5'h10;
   localparam logic [4:0] LEVEL_ONE = 5'h01;
   localparam logic [4:0] LEVEL_FOUR = 5'h04;
   localparam logic [4:0] LEVEL_EIGHT = 5'h08;
   localparam logic [2:0] THR_ONE = 3'h0;
   localparam logic [2:0] THR_FOUR = 3'h1;
   localparam logic [2:0] THR_EIGHT = 3'h2;
   localparam int IRQ_RX_OVERRUN = 0;
   localparam int IRQ_RX_TIMEOUT = 1;
   localparam int IRQ_RX_LEVEL = 2;
   localparam int IRQ_TX_LEVEL = 3;
   localparam int IRQ_TX_UNDERRUN = 4;
   localparam int IRQ_TX_EMPTY = 5;
   localparam int DMA_RX_BIT = 0;
   localparam int DMA_TX_BIT = 2;
   localparam logic [5:0] IRQ_ENABLE_RESET = 6'h00;
   localparam logic [7:0] DIVISOR_RESET = 8'h00;
   localparam logic [7:0] DIVISOR_MIN = 8'h02;
   localparam logic [2:0] DMA_CONTROL_RESET = 3'h0;
   localparam logic [2:0] DMA_CONTROL_MASK = 3'h5;
   localparam logic [5:0] TIMEOUT_LIMIT = 6'h20;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
   } ssid_bus_req_type;

   typedef struct packed {
      logic [4:0] tx_level;
      logic [4:0] rx_level;
      logic shifter_active;
   } ssid_fifo_state_type;
endpackage : ssid_pkg

//--- rtl/ssid_top.sv
// Status, prescaler, interrupt and DMA request logic of the serial port
`timescale 1ns/100ps
`default_nettype none
module ssid_top (
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic [4:0] TX_FIFO_LEVEL,
   input wire logic [4:0] RX_FIFO_LEVEL,
   input wire logic SHIFTER_ACTIVE,
   input wire logic RX_FRAME_WRITE,
   input wire logic RX_FIFO_READ,
   input wire logic TX_UNDERRUN,
   input wire logic [7:0] SERIAL_CLOCK_RATE,
   input wire logic [2:0] RX_IRQ_THRESHOLD,
   input wire logic [2:0] TX_IRQ_THRESHOLD,
   output logic SERIAL_BIT_TICK,
   output logic IRQ,
   output logic RX_DMA_REQ,
   output logic TX_DMA_REQ
);
   ssid_pkg::ssid_fifo_state_type fifo;
   ssid_pkg::ssid_bus_req_type req_next;
   ssid_pkg::ssid_bus_req_type req_reg;
   logic tx_fifo_empty;
   logic tx_fifo_has_space;
   logic rx_fifo_has_data;
   logic rx_fifo_full;
   logic port_busy;
   logic [4:0] fifo_status;
   logic [7:0] prescale_divisor_reg;
   logic [5:0] irq_enable_reg;
   logic [2:0] dma_control_reg;
   logic [5:0] raw_status;
   logic [5:0] masked_status;
   logic [31:0] read_mux;
   logic [31:0] hrdata_reg;
   logic write_phase;
   logic wr_prescale;
   logic wr_enable;
   logic wr_clear;
   logic wr_dma;
   logic [2:0] sticky_set;
   logic [2:0] sticky_clr;
   logic [2:0] sticky_reg;
   logic rx_level_raw;
   logic tx_level_raw;
   logic [4:0] rx_threshold_level;
   logic [4:0] tx_threshold_level;
   logic rx_thr_valid;
   logic tx_thr_valid;
   logic [5:0] timeout_cnt_reg;
   logic [5:0] timeout_cnt_next;
   logic timeout_hit;
   logic rate_run;
   logic pre_wrap;
   logic rate_wrap;
   logic [7:0] pre_cnt_reg;
   logic [7:0] pre_cnt_next;
   logic [7:0] rate_cnt_reg;
   logic [7:0] rate_cnt_next;
   logic bit_tick_reg;
   logic bit_tick_next;

   assign fifo = '{tx_level: TX_FIFO_LEVEL, rx_level: RX_FIFO_LEVEL,
                   shifter_active: SHIFTER_ACTIVE};

   // Live flags; an empty FIFO after reset gives the reset pattern
   assign tx_fifo_empty = (fifo.tx_level == 5'h00);
   assign tx_fifo_has_space = (fifo.tx_level != ssid_pkg::FIFO_FULL_LEVEL);
   assign rx_fifo_has_data = (fifo.rx_level != 5'h00);
   assign rx_fifo_full = (fifo.rx_level == ssid_pkg::FIFO_FULL_LEVEL);
   assign port_busy = fifo.shifter_active | ~tx_fifo_empty;
   assign fifo_status = {port_busy, rx_fifo_full, rx_fifo_has_data,
                         tx_fifo_has_space, tx_fifo_empty};

   // Bus slave: zero wait states, every answer OKAY
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign HRDATA = hrdata_reg;
   assign req_next = '{valid: HSEL & HTRANS[1] & HREADY,
                       write: HWRITE, addr: HADDR[7:0]};
   assign write_phase = req_reg.valid & req_reg.write;
   assign wr_prescale = write_phase &&
                        (req_reg.addr == ssid_pkg::OFS_PRESCALE);
   assign wr_enable = write_phase &&
                      (req_reg.addr == ssid_pkg::OFS_IRQ_ENABLE);
   assign wr_clear = write_phase && (req_reg.addr == ssid_pkg::OFS_IRQ_CLEAR);
   assign wr_dma = write_phase && (req_reg.addr == ssid_pkg::OFS_DMA_CONTROL);

   // Read data sampled at the address edge so it can leave a flip-flop
   assign read_mux =
      (HADDR[7:0] == ssid_pkg::OFS_FIFO_STATUS) ? {27'h0, fifo_status} :
      (HADDR[7:0] == ssid_pkg::OFS_PRESCALE) ? {24'h0, prescale_divisor_reg} :
      (HADDR[7:0] == ssid_pkg::OFS_IRQ_ENABLE) ? {26'h0, irq_enable_reg} :
      (HADDR[7:0] == ssid_pkg::OFS_RAW_STATUS) ? {26'h0, raw_status} :
      (HADDR[7:0] == ssid_pkg::OFS_MASKED_STATUS) ? {26'h0, masked_status} :
      (HADDR[7:0] == ssid_pkg::OFS_DMA_CONTROL) ? {29'h0, dma_control_reg} :
      32'h0000_0000;

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         req_reg <= '0;
         hrdata_reg <= 32'h0000_0000;
      end else begin
         req_reg <= req_next;
         if (req_next.valid && !HWRITE) begin
            hrdata_reg <= read_mux;
         end
      end
   end

   // Control registers; only defined bits are stored
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         prescale_divisor_reg <= ssid_pkg::DIVISOR_RESET;
         irq_enable_reg <= ssid_pkg::IRQ_ENABLE_RESET;
         dma_control_reg <= ssid_pkg::DMA_CONTROL_RESET;
      end else begin
         if (wr_prescale) begin
            prescale_divisor_reg <= HWDATA[7:0];
         end
         if (wr_enable) begin
            irq_enable_reg <= HWDATA[5:0];
         end
         if (wr_dma) begin
            dma_control_reg <= HWDATA[2:0] & ssid_pkg::DMA_CONTROL_MASK;
         end
      end
   end

   // Level thresholds; reserved codes never trigger
   assign rx_thr_valid = (RX_IRQ_THRESHOLD <= ssid_pkg::THR_EIGHT);
   assign tx_thr_valid = (TX_IRQ_THRESHOLD <= ssid_pkg::THR_EIGHT);
   assign rx_threshold_level =
      (RX_IRQ_THRESHOLD == ssid_pkg::THR_ONE) ? ssid_pkg::LEVEL_ONE :
      (RX_IRQ_THRESHOLD == ssid_pkg::THR_FOUR) ? ssid_pkg::LEVEL_FOUR :
      ssid_pkg::LEVEL_EIGHT;
   assign tx_threshold_level =
      (TX_IRQ_THRESHOLD == ssid_pkg::THR_ONE) ? ssid_pkg::LEVEL_ONE :
      (TX_IRQ_THRESHOLD == ssid_pkg::THR_FOUR) ? ssid_pkg::LEVEL_FOUR :
      ssid_pkg::LEVEL_EIGHT;
   assign rx_level_raw = rx_thr_valid &&
                         (fifo.rx_level >= rx_threshold_level);
   assign tx_level_raw = tx_thr_valid &&
                         (fifo.tx_level >= tx_threshold_level);

   // Timeout counter restarts on every read, so it fires once per idle spell
   assign timeout_hit = rx_fifo_has_data && !RX_FIFO_READ &&
                        (timeout_cnt_reg == ssid_pkg::TIMEOUT_LIMIT - 6'h01);
   assign timeout_cnt_next =
      (!rx_fifo_has_data || RX_FIFO_READ) ? 6'h00 :
      (timeout_cnt_reg == ssid_pkg::TIMEOUT_LIMIT) ? timeout_cnt_reg :
      timeout_cnt_reg + 6'h01;

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         timeout_cnt_reg <= 6'h00;
      end else begin
         timeout_cnt_reg <= timeout_cnt_next;
      end
   end

   // Latched sources: overrun, timeout, underrun in clear-bit order
   assign sticky_set = {TX_UNDERRUN, timeout_hit,
                        RX_FRAME_WRITE & rx_fifo_full};
   assign sticky_clr = wr_clear ? HWDATA[2:0] : 3'h0;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_sticky
         // A new event in the clearing cycle is kept
         always_ff @(posedge SYS_CLK or negedge RST_B) begin
            if (!RST_B) begin
               sticky_reg[gi] <= 1'b0;
            end else begin
               sticky_reg[gi] <= (sticky_reg[gi] & ~sticky_clr[gi]) |
                                 sticky_set[gi];
            end
         end
      end
   endgenerate

   assign raw_status = {tx_fifo_empty, sticky_reg[2], tx_level_raw,
                        rx_level_raw, sticky_reg[1], sticky_reg[0]};
   assign masked_status = raw_status & irq_enable_reg;
   assign IRQ = |masked_status;

   // Single requests follow the live FIFO state
   assign RX_DMA_REQ = dma_control_reg[ssid_pkg::DMA_RX_BIT] &
                       rx_fifo_has_data;
   assign TX_DMA_REQ = dma_control_reg[ssid_pkg::DMA_TX_BIT] &
                       tx_fifo_has_space;

   // Two cascaded counters; a divisor below two stops the bit clock
   assign rate_run = (prescale_divisor_reg >= ssid_pkg::DIVISOR_MIN);
   assign pre_wrap = (pre_cnt_reg >= prescale_divisor_reg - 8'h01);
   assign rate_wrap = (rate_cnt_reg >= SERIAL_CLOCK_RATE);
   assign pre_cnt_next = (!rate_run || pre_wrap) ? 8'h00 :
                         pre_cnt_reg + 8'h01;
   assign rate_cnt_next = !rate_run ? 8'h00 :
                          !pre_wrap ? rate_cnt_reg :
                          rate_wrap ? 8'h00 : rate_cnt_reg + 8'h01;
   assign bit_tick_next = rate_run & pre_wrap & rate_wrap;
   assign SERIAL_BIT_TICK = bit_tick_reg;

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         pre_cnt_reg <= 8'h00;
         rate_cnt_reg <= 8'h00;
         bit_tick_reg <= 1'b0;
      end else begin
         pre_cnt_reg <= pre_cnt_next;
         rate_cnt_reg <= rate_cnt_next;
         bit_tick_reg <= bit_tick_next;
      end
   end

   // Helper logic for the checks below
   logic [16:0] gap_cnt_reg;
   logic tick_seen_reg;
   logic cfg_same_reg;
   logic [16:0] expected_period;
   logic cfg_change;
   logic [7:0] rate_prev_reg;

   // Rate change seen in the same cycle it arrives, as the counters see it
   assign cfg_change = wr_prescale || (SERIAL_CLOCK_RATE != rate_prev_reg);
   assign expected_period = 17'({9'h000, prescale_divisor_reg} *
                                ({9'h000, SERIAL_CLOCK_RATE} + 17'h00001));

   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         gap_cnt_reg <= 17'h00000;
         tick_seen_reg <= 1'b0;
         cfg_same_reg <= 1'b0;
         rate_prev_reg <= 8'h00;
      end else begin
         rate_prev_reg <= SERIAL_CLOCK_RATE;
         gap_cnt_reg <= SERIAL_BIT_TICK ? 17'h00001 : gap_cnt_reg + 17'h00001;
         tick_seen_reg <= tick_seen_reg | SERIAL_BIT_TICK;
         cfg_same_reg <= cfg_change ? 1'b0 :
                         SERIAL_BIT_TICK ? 1'b1 : cfg_same_reg;
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_B);

   sequence s_read_of(logic [7:0] ofs);
      HSEL && HTRANS[1] && HREADY && !HWRITE && (HADDR[7:0] == ofs);
   endsequence

   sequence s_clear_overrun;
      wr_clear && HWDATA[0] && !(RX_FRAME_WRITE && rx_fifo_full);
   endsequence

   a_tx_empty_read: assert property (
      s_read_of(ssid_pkg::OFS_FIFO_STATUS) |=>
         HRDATA[0] == ($past(TX_FIFO_LEVEL) == 5'h00))
      else $error("tx empty flag wrong on read");

   a_tx_space_read: assert property (
      s_read_of(ssid_pkg::OFS_FIFO_STATUS) |=>
         HRDATA[1] == ($past(TX_FIFO_LEVEL) != 5'h10))
      else $error("tx space flag wrong on read");

   a_rx_flags_read: assert property (
      s_read_of(ssid_pkg::OFS_FIFO_STATUS) |=>
         HRDATA[3:2] == {$past(RX_FIFO_LEVEL) == 5'h10,
                         $past(RX_FIFO_LEVEL) != 5'h00})
      else $error("rx fifo flags wrong on read");

   a_busy_flag_read: assert property (
      s_read_of(ssid_pkg::OFS_FIFO_STATUS) |=>
         HRDATA[4] == ($past(SHIFTER_ACTIVE) || $past(TX_FIFO_LEVEL) != 5'h00))
      else $error("busy flag wrong on read");

   a_bit_rate_period: assert property (
      SERIAL_BIT_TICK && tick_seen_reg && cfg_same_reg && !cfg_change |->
         gap_cnt_reg == expected_period)
      else $error("bit tick period wrong");

   a_overrun_latch: assert property (
      RX_FRAME_WRITE && RX_FIFO_LEVEL == 5'h10 |=> raw_status[0] ##1
         (raw_status[0] || $past(wr_clear && HWDATA[0])))
      else $error("overrun not latched");

   a_timeout_fire: assert property (
      (RX_FIFO_LEVEL != 5'h00) && !RX_FIFO_READ && timeout_cnt_reg == 6'h1F
         |=> raw_status[1])
      else $error("timeout not raised");

   a_overrun_clear: assert property (
      s_clear_overrun |=> !raw_status[0])
      else $error("overrun not cleared");

   a_masked_read: assert property (
      s_read_of(ssid_pkg::OFS_MASKED_STATUS) |=>
         HRDATA[5:0] == $past(raw_status & irq_enable_reg))
      else $error("masked status read wrong");

   a_irq_output: assert property (
      IRQ == |(raw_status & irq_enable_reg))
      else $error("interrupt output wrong");

   a_rx_dma_gate: assert property (
      RX_DMA_REQ |-> dma_control_reg[0] && RX_FIFO_LEVEL != 5'h00)
      else $error("rx dma request while disabled");

   a_rx_level_eight: assert property (
      RX_IRQ_THRESHOLD == 3'h2 |-> raw_status[2] == (RX_FIFO_LEVEL >= 5'h08))
      else $error("rx level threshold wrong");

   a_reserved_zero: assert property (
      req_reg.valid && !req_reg.write |-> HRDATA[31:8] == 24'h000000 &&
         (req_reg.addr != ssid_pkg::OFS_DMA_CONTROL || !HRDATA[1]))
      else $error("reserved bits not zero");

   a_tx_dma_gate: assert property (
      TX_DMA_REQ == (dma_control_reg[2] && TX_FIFO_LEVEL != 5'h10))
      else $error("tx dma request wrong");

   a_underrun_latch: assert property (
      TX_UNDERRUN |=> raw_status[4])
      else $error("underrun not latched");

   a_tx_level_four: assert property (
      TX_IRQ_THRESHOLD == 3'h1 |-> raw_status[3] == (TX_FIFO_LEVEL >= 5'h04))
      else $error("tx level threshold wrong");

   a_level_reserved: assert property (
      RX_IRQ_THRESHOLD > 3'h2 |-> !raw_status[2])
      else $error("reserved rx threshold triggered");
endmodule : ssid_top
`default_nettype wire

//--- rtl/ssid_unused_placeholder_none.sv
// Intentionally empty: no further design files
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- verif/ssid_fifo_model.sv
// Behavioural FIFO levels and frame strobes beside the serial port block
`timescale 1ns/100ps
`default_nettype none
module ssid_fifo_model (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [3:0] cmd,
   output logic [4:0] tx_level,
   output logic [4:0] rx_level,
   output logic frame_write,
   output logic fifo_read
);
   // Command bits: rx push, rx pop, tx push, tx pop
   assign frame_write = cmd[3];
   assign fifo_read = cmd[2];
   // A full FIFO drops the frame, so an overrun leaves the level at 16
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rx_level <= 5'h00;
         tx_level <= 5'h00;
      end else begin
         rx_level <= rx_level + 5'(cmd[3] && rx_level != 5'h10)
            - 5'(cmd[2] && rx_level != 5'h00);
         tx_level <= tx_level + 5'(cmd[1] && tx_level != 5'h10)
            - 5'(cmd[0] && tx_level != 5'h00);
      end
   end
endmodule : ssid_fifo_model
`default_nettype wire

//--- verif/tb_spi_status_irq_dma.sv
// Self-checking bench for the serial port status and interrupt block
`timescale 1ns/100ps
`default_nettype none
module tb_spi_status_irq_dma;
   logic SYS_CLK, RST_B, HSEL, HWRITE, HREADYOUT, HRESP, SHIFTER_ACTIVE;
   logic TX_UNDERRUN, SERIAL_BIT_TICK, IRQ, RX_DMA_REQ, TX_DMA_REQ;
   logic RX_FRAME_WRITE, RX_FIFO_READ, rd_phase, pin_phase, ovr, tmo, und;
   logic [31:0] HADDR, HWDATA, HRDATA, rnd;
   logic [1:0] HTRANS;
   logic [4:0] TX_FIFO_LEVEL, RX_FIFO_LEVEL;
   logic [7:0] SERIAL_CLOCK_RATE;
   logic [2:0] RX_IRQ_THRESHOLD, TX_IRQ_THRESHOLD;
   logic [3:0] cmd;
   logic [31:0] exp_q[$];
   int fails, cmp_count, r, t, seed;
   ssid_top uut (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .HSEL(HSEL),
      .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2),
      .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
      .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TX_FIFO_LEVEL(TX_FIFO_LEVEL),
      .RX_FIFO_LEVEL(RX_FIFO_LEVEL), .SHIFTER_ACTIVE(SHIFTER_ACTIVE),
      .RX_FRAME_WRITE(RX_FRAME_WRITE), .RX_FIFO_READ(RX_FIFO_READ),
      .TX_UNDERRUN(TX_UNDERRUN), .SERIAL_CLOCK_RATE(SERIAL_CLOCK_RATE),
      .RX_IRQ_THRESHOLD(RX_IRQ_THRESHOLD), .TX_IRQ_THRESHOLD(TX_IRQ_THRESHOLD),
      .SERIAL_BIT_TICK(SERIAL_BIT_TICK), .IRQ(IRQ), .RX_DMA_REQ(RX_DMA_REQ),
      .TX_DMA_REQ(TX_DMA_REQ));
   ssid_fifo_model fifo_side (.clk(SYS_CLK), .rst_b(RST_B), .cmd(cmd),
      .tx_level(TX_FIFO_LEVEL), .rx_level(RX_FIFO_LEVEL),
      .frame_write(RX_FRAME_WRITE), .fifo_read(RX_FIFO_READ));
   initial begin
      SYS_CLK = 1'b0;
      forever #4 SYS_CLK = ~SYS_CLK;
   end
   task cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask : cmp
   task finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test
   // Only one observation is open at a time, so one queue serves both
   always @(posedge SYS_CLK) begin
      if (rd_phase) cmp("read data", exp_q.pop_front(), HRDATA);
      if (rd_phase) cmp("bus response", 32'h0, {31'h0, HRESP});
      if (pin_phase) cmp("irq dma pins", exp_q.pop_front(),
         {29'h0, IRQ, RX_DMA_REQ, TX_DMA_REQ});
   end
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HADDR <= {24'h0, a};
      HWRITE <= w;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= d;
      rd_phase <= !w;
      do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
      rd_phase <= 1'b0;
   endtask : bus
   task rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask : rd
   task wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task pins(input logic [2:0] e);
      exp_q.push_back({29'h0, e});
      pin_phase <= 1'b1;
      @(posedge SYS_CLK);
      pin_phase <= 1'b0;
      @(posedge SYS_CLK);
   endtask : pins
   task fifo(input logic [3:0] c, input int n);
      repeat (n) begin
         cmd <= c;
         r = r + int'(c[3] && r != 16) - int'(c[2] && r != 0);
         t = t + int'(c[1] && t != 16) - int'(c[0] && t != 0);
         @(posedge SYS_CLK);
      end
      cmd <= 4'h0;
      @(posedge SYS_CLK);
   endtask : fifo
   function automatic int lv(input logic [2:0] s);
      // Reserved codes never trigger: no level reaches 17
      return (s == 3'h0) ? 1 : (s == 3'h1) ? 4 : (s == 3'h2) ? 8 : 17;
   endfunction : lv
   function automatic logic [31:0] raw_exp();
      return {26'h0, t == 0, und, t >= lv(TX_IRQ_THRESHOLD),
         r >= lv(RX_IRQ_THRESHOLD), tmo, ovr};
   endfunction : raw_exp
   function automatic logic [31:0] st_exp();
      return {27'h0, SHIFTER_ACTIVE || t != 0, r == 16, r != 0, t != 16,
         t == 0};
   endfunction : st_exp
   // Push and pop together keep the level but restart the read timeout
   task chk_raw();
      if (r > 0 && r < 16) fifo(4'hC, 1);
      rd(8'h18, raw_exp());
   endtask : chk_raw
   task tick(input logic [7:0] d, input logic [7:0] s, input int e);
      int n;
      wr(8'h10, {24'h0, d});
      SERIAL_CLOCK_RATE <= s;
      n = 0;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         do begin
            @(posedge SYS_CLK);
            n++;
         end while (SERIAL_BIT_TICK !== 1'b1 && n < 600);
      end
      cmp("tick period", e, n);
   endtask : tick
   initial begin
      repeat (6000) @(posedge SYS_CLK);
      fails++;
      finish_test();
   end
   initial begin
      seed = 32'h04d838e4;
      {RST_B, HSEL, HWRITE, SHIFTER_ACTIVE, TX_UNDERRUN} = 5'h00;
      {rd_phase, pin_phase, ovr, tmo, und} = 5'h00;
      {HADDR, HWDATA, HTRANS, cmd} = 70'h0;
      SERIAL_CLOCK_RATE = 8'h02;
      {RX_IRQ_THRESHOLD, TX_IRQ_THRESHOLD} = 6'h00;
      {fails, cmp_count, r, t} = 128'h0;
      repeat (20) @(posedge SYS_CLK);
      RST_B <= 1'b1;
      @(posedge SYS_CLK);
      rd(8'h0C, st_exp());
      rd(8'h14, 32'h0);
      rd(8'h18, raw_exp());
      rd(8'h1C, 32'h0);
      rd(8'h20, 32'h0);
      rd(8'h24, 32'h0);
      rd(8'h3C, 32'h0);
      pins(3'h0);
      $display("test reset done");
      wr(8'h10, 32'hFFFFFFFE);
      rd(8'h10, 32'h000000FE);
      wr(8'h24, 32'hFFFFFFFF);
      rd(8'h24, 32'h00000005);
      wr(8'h18, 32'hFFFFFFFF);
      rd(8'h18, raw_exp());
      rnd = $random(seed);
      wr(8'h14, rnd);
      rd(8'h14, {26'h0, rnd[5:0]});
      wr(8'h14, 32'h0);
      $display("test registers done");
      for (int s = 0; s < 3; s++) begin
         RX_IRQ_THRESHOLD <= 3'(s);
         TX_IRQ_THRESHOLD <= 3'(s);
         @(posedge SYS_CLK);
         fifo(4'hA, lv(3'(s)) - 1 - r);
         chk_raw();
         fifo(4'hA, 1);
         chk_raw();
      end
      rnd = $random(seed);
      RX_IRQ_THRESHOLD <= {1'b1, rnd[1:0]};
      TX_IRQ_THRESHOLD <= 3'h3;
      @(posedge SYS_CLK);
      chk_raw();
      RX_IRQ_THRESHOLD <= 3'h2;
      TX_IRQ_THRESHOLD <= 3'h2;
      fifo(4'hA, 8);
      rd(8'h0C, st_exp());
      fifo(4'h8, 1);
      ovr = 1'b1;
      wr(8'h14, 32'h1);
      rd(8'h18, raw_exp());
      rd(8'h1C, 32'h1);
      pins(3'b110);
      fifo(4'h4, 1);
      wr(8'h20, 32'h1);
      ovr = 1'b0;
      pins(3'b010);
      TX_UNDERRUN <= 1'b1;
      @(posedge SYS_CLK);
      TX_UNDERRUN <= 1'b0;
      und = 1'b1;
      wr(8'h14, 32'h10);
      chk_raw();
      pins(3'b110);
      wr(8'h20, 32'h4);
      und = 1'b0;
      pins(3'b010);
      wr(8'h24, 32'h0);
      pins(3'b000);
      $display("test events done");
      wr(8'h14, 32'h2);
      repeat (40) @(posedge SYS_CLK);
      tmo = 1'b1;
      chk_raw();
      pins(3'b100);
      wr(8'h20, 32'h2);
      tmo = 1'b0;
      chk_raw();
      fifo(4'h5, 16);
      wr(8'h24, 32'h5);
      pins(3'b001);
      SHIFTER_ACTIVE <= 1'b1;
      @(posedge SYS_CLK);
      rd(8'h0C, st_exp());
      SHIFTER_ACTIVE <= 1'b0;
      $display("test timeout done");
      tick(8'h04, 8'h02, 12);
      tick(8'h02, 8'h00, 2);
      tick(8'h06, 8'h03, 24);
      $display("test bit rate done");
      finish_test();
   end
endmodule : tb_spi_status_irq_dma
`default_nettype wire
